// ===== hdl/cko_pkg.sv
// Package for the clock output control block: register map, field layouts,
// select codes, divider factors and reset values.
// Assumes one system clock and a byte-wide register port.
package cko_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] CKO_ADDR_TRIM = 8'h3c;
  localparam logic [7:0] CKO_ADDR_CTRL = 8'h3d;
  localparam logic [7:0] CKO_ADDR_OUTDIV = 8'h3e;
  localparam logic [7:0] CKO_ADDR_GPIO = 8'h50;
  localparam logic [7:0] CKO_ADDR_STATUS = 8'h51;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CKO_RESET_TRIM = 8'h00;
  localparam logic [7:0] CKO_RESET_CTRL = 8'h00;
  localparam logic [7:0] CKO_RESET_OUTDIV = 8'h08;
  localparam logic [7:0] CKO_RESET_GPIO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the own pin register and the status register
  localparam int CKO_GPIO_VALUE_BIT = 0;
  localparam int CKO_GPIO_DRIVE_BIT = 1;
  localparam int CKO_STAT_PIN_IN_BIT = 0;
  localparam int CKO_STAT_PIN_OUT_BIT = 1;
  localparam int CKO_STAT_PIN_OE_BIT = 2;
  localparam int CKO_STAT_PLL_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Clock output select codes
  typedef enum logic [3:0] {
    CKO_SEL_GPIO = 4'h0,
    CKO_SEL_PLL = 4'h1,
    CKO_SEL_LOW = 4'h2,
    CKO_SEL_HIGH = 4'h3,
    CKO_SEL_XTAL = 4'h4,
    CKO_SEL_XTAL_DIV2 = 4'h5,
    CKO_SEL_XTAL_DIV4 = 4'h6,
    CKO_SEL_XTAL_DIV8 = 4'h7,
    CKO_SEL_TIMER_ZERO = 4'h8,
    CKO_SEL_TIMER1 = 4'h9,
    CKO_SEL_TIMER2 = 4'ha,
    CKO_SEL_TIMER_THREE = 4'hb
  } cko_select_type;

  localparam logic [3:0] CKO_SEL_FIRST_RESERVED = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Feedback multiplication factors and output divider floor
  localparam logic [4:0] CKO_FB_MULT_00 = 5'h17;
  localparam logic [4:0] CKO_FB_MULT_01 = 5'h1b;
  localparam logic [4:0] CKO_FB_MULT_10 = 5'h1c;
  localparam logic [4:0] CKO_FB_MULT_11 = 5'h17;
  localparam logic [7:0] CKO_OUTDIV_MIN = 8'h08;

  // Slow oscillator reload base in system clocks; half period is base plus trim plus one
  localparam logic [8:0] CKO_SLOW_BASE_CYCLES = 9'h040;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [3:0] select;
    logic enable;
    logic power_down;
    logic [1:0] feedback;
  } cko_ctrl_type;

  typedef struct packed {
    logic [4:0] feedback_factor;
    logic [7:0] output_divider;
    logic power_down;
  } cko_pll_cfg_type;

endpackage

// ===== hdl/cko_sync.sv
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes inputs are slow relative to the system clock.
`timescale 1ns/1ps
module cko_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // cko_sync

// ===== hdl/cko_xtal_div.sv
// Divider chain for the synchronised crystal level: by two, four and eight.
// Assumes the crystal level is already synchronised to the system clock.
`timescale 1ns/1ps
module cko_xtal_div (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic xtal_level_in,
  output logic [2:0] div_out
);
  logic xtal_prev;
  wire xtal_rise = xtal_level_in & ~xtal_prev;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      xtal_prev <= 1'b0;
      div_out <= 3'h0;
    end else begin
      xtal_prev <= xtal_level_in;
      if (xtal_rise) begin
        div_out <= div_out + 3'h1;
      end
    end
  end
endmodule // cko_xtal_div

// ===== hdl/cko_top.sv
// Clock output control: PLL settings, clock output pin selection, slow
// oscillator trim. Registers reached over a plain byte-wide port.
// Assumes crystal, PLL clock and pin levels arrive asynchronously; timer
// overflow pulses come from logic on the same clock.
//
// Functional notes
// - Select zero: pin is I/O; one: PLL
// - Select two holds low, three holds high
// - Select four routes undivided crystal clock
// - Selects five to seven: crystal by 2/4/8
// - Selects eight to eleven toggle on timer overflow
// - Clock only driven while output enable set
// - Feedback code gives factor 23, 27, 28, 23
// - Output divider divides by value, 8 to 255
// - PLL clock: reference times factor, halved, divided
// - Larger trim gives lower slow oscillator frequency
`timescale 1ns/1ps
module cko_top
  import cko_pkg::*;
#(
  parameter int TIMERS = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic xtal_clk_in,
  input wire logic pll_clk_in,
  input wire logic [TIMERS-1:0] timer_overflow_in,
  input wire logic clock_out_pin_in,
  output logic clock_out_pin_out,
  output logic clock_out_pin_oe_out,
  output cko_pll_cfg_type pll_cfg_out,
  output logic [7:0] slow_osc_trim_out,
  output logic slow_osc_clk_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  cko_ctrl_type ctrl;
  logic [7:0] slow_osc_trim;
  logic [7:0] output_divider;
  logic [7:0] gpio;

  wire wr_trim = reg_write_in && (reg_addr_in == CKO_ADDR_TRIM);
  wire wr_ctrl = reg_write_in && (reg_addr_in == CKO_ADDR_CTRL);
  wire wr_outdiv = reg_write_in && (reg_addr_in == CKO_ADDR_OUTDIV);
  wire wr_gpio = reg_write_in && (reg_addr_in == CKO_ADDR_GPIO);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl <= cko_ctrl_type'(CKO_RESET_CTRL);
      slow_osc_trim <= CKO_RESET_TRIM;
      output_divider <= CKO_RESET_OUTDIV;
      gpio <= CKO_RESET_GPIO;
    end else begin
      if (wr_ctrl) ctrl <= cko_ctrl_type'(reg_wdata_in);
      if (wr_trim) slow_osc_trim <= reg_wdata_in;
      if (wr_outdiv) output_divider <= reg_wdata_in;
      if (wr_gpio) gpio <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and crystal dividers
  logic [2:0] sync_levels;
  logic [2:0] xtal_div;
  wire xtal_s = sync_levels[0];
  wire pll_s = sync_levels[1];
  wire pin_s = sync_levels[2];

  cko_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({clock_out_pin_in, pll_clk_in, xtal_clk_in}),
    .sync_out(sync_levels)
  );

  cko_xtal_div u_div (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .xtal_level_in(xtal_s),
    .div_out(xtal_div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timer overflow toggles
  logic [TIMERS-1:0] timer_toggle;

  genvar t;
  generate
    for (t = 0; t < TIMERS; t++) begin : g_timer
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          timer_toggle[t] <= 1'b0;
        end else if (timer_overflow_in[t]) begin
          timer_toggle[t] <= ~timer_toggle[t];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin source selection
  // Stopped PLL clock
  wire pll_gated = pll_s & ~ctrl.power_down;
  wire gpio_value = gpio[CKO_GPIO_VALUE_BIT];
  wire gpio_drive = gpio[CKO_GPIO_DRIVE_BIT];
  wire [3:0] timer_src = 4'(timer_toggle);
  wire [15:0] sources = {4'h0, timer_src, xtal_div[2], xtal_div[1], xtal_div[0], xtal_s,
                         1'b1, 1'b0, pll_gated, gpio_value};
  wire is_gpio = (ctrl.select == CKO_SEL_GPIO);
  wire selected = sources[ctrl.select];
  wire next_pin_oe = is_gpio ? gpio_drive : ctrl.enable;
  wire next_pin_val = is_gpio ? gpio_value : (ctrl.enable & selected);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      clock_out_pin_out <= 1'b0;
      clock_out_pin_oe_out <= 1'b0;
    end else begin
      clock_out_pin_out <= next_pin_val;
      clock_out_pin_oe_out <= next_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL settings to the analog PLL
  // Feedback factor decode
  wire [4:0] next_fb_factor = (ctrl.feedback == 2'h0) ? CKO_FB_MULT_00 :
                              (ctrl.feedback == 2'h1) ? CKO_FB_MULT_01 :
                              (ctrl.feedback == 2'h2) ? CKO_FB_MULT_10 : CKO_FB_MULT_11;
  wire [7:0] next_out_div = (output_divider < CKO_OUTDIV_MIN) ? CKO_OUTDIV_MIN : output_divider;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pll_cfg_out <= '0;
    end else begin
      pll_cfg_out <= '{feedback_factor: next_fb_factor, output_divider: next_out_div,
                       power_down: ctrl.power_down};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator
  logic [8:0] slow_count;
  wire [8:0] slow_reload = CKO_SLOW_BASE_CYCLES + {1'b0, slow_osc_trim};
  wire slow_wrap = (slow_count == 9'h000);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      slow_count <= CKO_SLOW_BASE_CYCLES;
      slow_osc_clk_out <= 1'b0;
      slow_osc_trim_out <= CKO_RESET_TRIM;
    end else begin
      slow_osc_trim_out <= slow_osc_trim;
      if (slow_wrap) begin
        slow_count <= slow_reload;
        slow_osc_clk_out <= ~slow_osc_clk_out;
      end else begin
        slow_count <= slow_count - 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[CKO_STAT_PIN_IN_BIT] = pin_s;
    status[CKO_STAT_PIN_OUT_BIT] = clock_out_pin_out;
    status[CKO_STAT_PIN_OE_BIT] = clock_out_pin_oe_out;
    status[CKO_STAT_PLL_BIT] = pll_gated;
  end
  wire [7:0] next_rdata = (reg_addr_in == CKO_ADDR_TRIM) ? slow_osc_trim :
                          (reg_addr_in == CKO_ADDR_CTRL) ? 8'(ctrl) :
                          (reg_addr_in == CKO_ADDR_OUTDIV) ? output_divider :
                          (reg_addr_in == CKO_ADDR_GPIO) ? gpio :
                          (reg_addr_in == CKO_ADDR_STATUS) ? status : 8'h00;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_gpio_pin_mode: assert property (
    is_gpio |=> (clock_out_pin_out == $past(gpio_value)) && (clock_out_pin_oe_out == $past(gpio_drive)))
    else $error("pin does not follow own drive register in select zero");

  a_pll_pin_follow: assert property (
    (ctrl.select == CKO_SEL_PLL) && ctrl.enable && !ctrl.power_down |=> clock_out_pin_out == $past(pll_s))
    else $error("pin does not follow PLL clock");

  a_const_levels: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_LOW || ctrl.select == CKO_SEL_HIGH)
    |=> clock_out_pin_oe_out && (clock_out_pin_out == ($past(ctrl.select) == CKO_SEL_HIGH)))
    else $error("constant level select wrong");

  a_xtal_route: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_XTAL) |=> clock_out_pin_out == $past(xtal_s))
    else $error("crystal clock not routed");

  a_xtal_div8: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_XTAL_DIV8) |=> clock_out_pin_out == $past(xtal_div[2]))
    else $error("divide by eight not routed");

  a_timer_toggle: assert property (
    timer_overflow_in[0] ##1 (ctrl.enable && ctrl.select == CKO_SEL_TIMER_ZERO && $stable(ctrl))
    |=> clock_out_pin_out != $past(timer_toggle[0], 2))
    else $error("timer overflow did not toggle pin");

  a_enable_gate: assert property (
    !ctrl.enable && !is_gpio |=> !clock_out_pin_oe_out && !clock_out_pin_out)
    else $error("pin driven while output disabled");

  a_fb_factor: assert property (
    ctrl.feedback == 2'h2 |=> pll_cfg_out.feedback_factor == 5'h1c)
    else $error("feedback factor for code two wrong");

  a_div_floor: assert property (
    output_divider < 8'h08 |=> pll_cfg_out.output_divider == 8'h08)
    else $error("reserved output divider not floored");

  a_div_pass: assert property (
    output_divider >= 8'h08 |=> pll_cfg_out.output_divider == $past(output_divider))
    else $error("output divider not passed to PLL");

  a_trim_period: assert property (
    slow_wrap |=> slow_count == 9'h040 + {1'b0, $past(slow_osc_trim)})
    else $error("slow oscillator reload ignores trim");

  a_reserved_low: assert property (
    ctrl.enable && (ctrl.select >= CKO_SEL_FIRST_RESERVED) |=> !clock_out_pin_out)
    else $error("reserved select not low");

  a_pll_down_static: assert property (
    ctrl.power_down && ctrl.enable && (ctrl.select == CKO_SEL_PLL) |=> !clock_out_pin_out)
    else $error("PLL clock running in power down");

  a_xtal_div2: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_XTAL_DIV2) |=> clock_out_pin_out == $past(xtal_div[0]))
    else $error("divide by two not routed");

  a_xtal_div4: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_XTAL_DIV4) |=> clock_out_pin_out == $past(xtal_div[1]))
    else $error("divide by four not routed");

  a_timer_three: assert property (
    ctrl.enable && (ctrl.select == CKO_SEL_TIMER_THREE) |=> clock_out_pin_out == $past(timer_src[3]))
    else $error("timer three toggle not routed");

  a_timer_flip: assert property (
    timer_overflow_in[0] |=> timer_src[0] != $past(timer_src[0]))
    else $error("timer zero overflow did not flip toggle");

  a_enable_oe: assert property (
    ctrl.enable && !is_gpio |=> clock_out_pin_oe_out)
    else $error("pin not driven while output enabled");

  a_fb_code_zero: assert property (
    ctrl.feedback == 2'h0 |=> pll_cfg_out.feedback_factor == 5'h17)
    else $error("feedback factor for code zero wrong");

  a_fb_code_one: assert property (
    ctrl.feedback == 2'h1 |=> pll_cfg_out.feedback_factor == 5'h1b)
    else $error("feedback factor for code one wrong");

  a_fb_code_three: assert property (
    ctrl.feedback == 2'h3 |=> pll_cfg_out.feedback_factor == 5'h17)
    else $error("feedback factor for code three wrong");

  a_power_down_cfg: assert property (
    ctrl.power_down |=> pll_cfg_out.power_down)
    else $error("power down not passed to PLL");

  a_pll_gate_off: assert property (
    ctrl.power_down |-> !pll_gated)
    else $error("PLL source not stopped in power down");

  a_slow_count_down: assert property (
    !slow_wrap |=> slow_count == $past(slow_count) - 9'h001)
    else $error("slow oscillator count did not step down");

  a_trim_copy: assert property (
    1'b1 |=> slow_osc_trim_out == $past(slow_osc_trim))
    else $error("trim output does not follow trim register");

  a_trim_write: assert property (
    wr_trim |=> slow_osc_trim == $past(reg_wdata_in))
    else $error("trim write lost");

  a_ctrl_write: assert property (
    wr_ctrl |=> 8'(ctrl) == $past(reg_wdata_in))
    else $error("control write lost");

  a_outdiv_write: assert property (
    wr_outdiv |=> output_divider == $past(reg_wdata_in))
    else $error("output divider write lost");

  a_gpio_write: assert property (
    wr_gpio |=> gpio == $past(reg_wdata_in))
    else $error("own pin register write lost");

  a_rdata_idle: assert property (
    !reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read cycle");

  a_rdata_trim: assert property (
    reg_read_in && (reg_addr_in == CKO_ADDR_TRIM) |=> reg_rdata_out == $past(slow_osc_trim))
    else $error("trim read data wrong");

  c_pll_out: cover property (ctrl.enable && ctrl.select == CKO_SEL_PLL ##1 clock_out_pin_out);
  c_div4_out: cover property (ctrl.enable && ctrl.select == CKO_SEL_XTAL_DIV4 ##1 clock_out_pin_out);
  c_timer_three_out: cover property (ctrl.enable && ctrl.select == CKO_SEL_TIMER_THREE ##1 clock_out_pin_out);
  c_slow_tick: cover property (slow_wrap && slow_osc_trim == 8'h20);
  c_timer_zero_flip: cover property (timer_overflow_in[0] && ctrl.enable && ctrl.select == CKO_SEL_TIMER_ZERO);

endmodule // cko_top

// ===== tb/cko_testbench.sv
// Self-checking bench for the clock output control block.
// Assumes the register port, crystal, PLL clock and timer pulses are driven here.
`timescale 1ns/1ps
module testbench;
  import cko_pkg::*;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic xtal_clk_in = 1'b0, pll_clk_in = 1'b0;
  logic [3:0] timer_overflow_in = 4'h0;
  logic [7:0] reg_rdata_out, trim_o;
  logic pin_out, pin_oe, slow, p0;
  wire pin_level = pin_oe ? pin_out : 1'b1;
  cko_pll_cfg_type cfg;
  logic [4:0] mult [4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
  int err_count = 0, checks = 0, r, e;
  cko_top #(.TIMERS(4)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .xtal_clk_in(xtal_clk_in), .pll_clk_in(pll_clk_in),
    .timer_overflow_in(timer_overflow_in), .clock_out_pin_in(pin_level), .clock_out_pin_out(pin_out),
    .clock_out_pin_oe_out(pin_oe), .pll_cfg_out(cfg), .slow_osc_trim_out(trim_o), .slow_osc_clk_out(slow));

  ////////////////////////////////////////////////////////////////////////////
  // Clocks and watchdog
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    forever #18.4 xtal_clk_in = ~xtal_clk_in;
  end
  initial begin
    forever #20 pll_clk_in = ~pll_clk_in;
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and measurement tasks
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_cnt(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1;
    chk8(name, exp, reg_rdata_out);
  endtask
  task automatic ctl(input logic [3:0] sel, input logic en, input logic pd, input logic [1:0] fb);
    wr(CKO_ADDR_CTRL, {sel, en, pd, fb});
    repeat (10) @(posedge clk_sys_in);
  endtask
  task automatic pins(input string name, input logic [1:0] exp);
    #1;
    chk8(name, {6'h00, exp}, {6'h00, pin_oe, pin_out});
  endtask
  task automatic rises(input int cyc, output int n);
    logic prev;
    #1;
    prev = pin_out;
    n = 0;
    repeat (cyc) begin
      @(posedge clk_sys_in);
      #1;
      if (pin_out === 1'b1 && prev === 1'b0) n++;
      prev = pin_out;
    end
  endtask
  task automatic half_period(output int n);
    logic s;
    @(posedge clk_sys_in);
    #1;
    s = slow;
    while (slow === s) begin
      @(posedge clk_sys_in);
      #1;
    end
    s = slow;
    n = 0;
    while (slow === s && n < 2000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rchk("trim reset", CKO_ADDR_TRIM, CKO_RESET_TRIM);
    rchk("ctrl reset", CKO_ADDR_CTRL, CKO_RESET_CTRL);
    rchk("outdiv reset", CKO_ADDR_OUTDIV, CKO_RESET_OUTDIV);
    rchk("gpio reset", CKO_ADDR_GPIO, CKO_RESET_GPIO);
    wr(8'h7f, 8'h5a);
    rchk("unmapped", 8'h7f, 8'h00);
    wr(CKO_ADDR_GPIO, 8'h03);
    repeat (3) @(posedge clk_sys_in);
    pins("gpio drive high", 2'b11);
    wr(CKO_ADDR_GPIO, 8'h02);
    repeat (3) @(posedge clk_sys_in);
    pins("gpio drive low", 2'b10);
    for (int f = 0; f < 4; f++) begin
      ctl(4'h1, 1'b1, 1'b0, f[1:0]);
      chk8("feedback factor", {3'h0, mult[f]}, {3'h0, cfg.feedback_factor});
    end
    rises(2000, r);
    chk_cnt("pll on pin", 248, 252, r);
    ctl(4'h1, 1'b1, 1'b1, 2'h0);
    chk8("power down flag", 8'h01, {7'h00, cfg.power_down});
    rchk("status pll down", CKO_ADDR_STATUS, 8'h04);
    rises(400, r);
    chk_cnt("pll stopped", 0, 0, r);
    ctl(4'h2, 1'b1, 1'b0, 2'h0);
    pins("hold low", 2'b10);
    ctl(4'h3, 1'b1, 1'b0, 2'h0);
    pins("hold high", 2'b11);
    for (int k = 0; k < 4; k++) begin
      ctl(4'h4 + k[3:0], 1'b1, 1'b0, 2'h0);
      rises(2000, r);
      e = 271 >> k;
      chk_cnt("crystal on pin", e - 2, e + 2, r);
    end
    ctl(4'h4, 1'b0, 1'b0, 2'h0);
    pins("disabled release", 2'b00);
    rises(400, r);
    chk_cnt("disabled quiet", 0, 0, r);
    for (int k = 0; k < 4; k++) begin
      ctl(4'h8 + k[3:0], 1'b1, 1'b0, 2'h0);
      #1;
      p0 = pin_out;
      for (int j = 0; j < 4; j++) begin
        @(posedge clk_sys_in);
        timer_overflow_in <= 4'h1 << j;
        @(posedge clk_sys_in);
        timer_overflow_in <= 4'h0;
        repeat (4) @(posedge clk_sys_in);
      end
      pins("timer toggle", {1'b1, ~p0});
    end
    for (int c = 12; c < 16; c++) begin
      ctl(c[3:0], 1'b1, 1'b0, 2'h0);
      pins("reserved select", 2'b10);
    end
    wr(CKO_ADDR_OUTDIV, 8'h08);
    rchk("outdiv low", CKO_ADDR_OUTDIV, 8'h08);
    chk8("outdiv to pll", 8'h08, cfg.output_divider);
    wr(CKO_ADDR_OUTDIV, 8'hff);
    rchk("outdiv high", CKO_ADDR_OUTDIV, 8'hff);
    chk8("outdiv to pll", 8'hff, cfg.output_divider);
    wr(CKO_ADDR_OUTDIV, 8'h07);
    rchk("outdiv reserved", CKO_ADDR_OUTDIV, 8'h07);
    chk8("outdiv floor", CKO_OUTDIV_MIN, cfg.output_divider);
    wr(CKO_ADDR_TRIM, 8'h00);
    half_period(r);
    half_period(r);
    chk_cnt("slow half period", 65, 65, r);
    wr(CKO_ADDR_TRIM, 8'h20);
    rchk("trim readback", CKO_ADDR_TRIM, 8'h20);
    chk8("trim out", 8'h20, trim_o);
    half_period(r);
    half_period(r);
    chk_cnt("slow half period", 97, 97, r);
    tally_and_finish();
  end
endmodule // testbench
